// >>> dms_pkg.sv
package dms_pkg;

   // Bus geometry: each register is one aligned word, index times four.
   localparam int ADDR_W = 10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_STAT = 8'h01;
   localparam logic [7:0] IDX_IRQ_STS = 8'h02;
   localparam logic [7:0] IDX_IRQ_MSK = 8'h03;
   localparam logic [7:0] IDX_WIN = 8'h20;
   localparam logic [7:0] IDX_MATCH_FLAGS = 8'h27;

   // Control register fields.
   localparam int CTRL_ARM = 0;
   localparam int CTRL_BANK_LSB = 2;
   localparam int CTRL_NSS_LSB = 4;
   localparam logic [1:0] BANK_FLAGS = 2'h3;

   // Comparator control byte fields.
   localparam int CMP_EN = 0;
   localparam int CMP_DATA_EN = 1;

   // Interrupt status bits.
   localparam int IRQ_FINAL = 0;
   localparam int IRQ_FLAG = 1;

   // Reset values.
   localparam logic [1:0] RST_BANK = 2'h0;
   localparam logic [3:0] RST_NSS = 4'h0;
   localparam logic [2:0] RST_FLAGS = 3'h0;
   localparam logic [1:0] RST_IRQ = 2'h0;

   // Next-state select codes for State3.
   localparam logic [3:0] NSS_3 = 4'h3;
   localparam logic [3:0] NSS_4 = 4'h4;
   localparam logic [3:0] NSS_5 = 4'h5;
   localparam logic [3:0] NSS_6 = 4'h6;
   localparam logic [3:0] NSS_7 = 4'h7;
   localparam logic [3:0] NSS_A = 4'hA;
   localparam logic [3:0] NSS_D = 4'hD;
   localparam logic [3:0] NSS_E = 4'hE;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_ONE = 3'b001,
      SEQ_TWO = 3'b010,
      SEQ_THREE = 3'b011,
      SEQ_FINAL = 3'b100
   } dms_seq_t;

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_idx;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      dms_seq_t seq;
      logic [2:0] flags;
      logic [1:0] bank;
      logic [3:0] nss;
      logic [2:0][7:0] cmp_ctl;
      logic [2:0][23:0] cmp_addr;
      logic [15:0] a_data;
      logic [15:0] a_mask;
      logic [1:0] irq_sts;
      logic [1:0] irq_msk;
   } dms_state_t;

endpackage : dms_pkg

// >>> dms_debug_match_sequencer.sv
// Notes on behaviour
// RULE_01: In State3, matches not listed for the select code cause no move.
// RULE_02: Code 0011: channel 1 goes final, channel 2 goes to State1.
// RULE_03: Code 0100: channel 1 to State2; code 0101: channel 1 goes final.
// RULE_04: Code 0110: ch2 to State2, ch0 final; code 0111: only ch0 final.
// RULE_05: Code 1010: channel 1 or 2 to State1, channel 0 goes final.
// RULE_06: Code 1101: channel 1 or 2 goes final, channel 0 to State1.
// RULE_07: Code 1110: channel 0 to State2, channel 2 goes final.
// RULE_08: Simultaneous matches: final-state match first, then lowest channel.
// RULE_09: Match flags readable only with bank select 11; writes ignored.
// RULE_10: Three match flags, one per channel, set on match in session.
// RULE_11: A set flag stays set until the next arming write clears it.
// RULE_12: Software writes never clear flags; only arming does.
// RULE_13: A set flag never blocks another channel's flag from setting.
// RULE_14: Repeat matches on a flagged channel leave that flag unchanged.
// RULE_15: Comparator banks share an 8-byte window picked by bank select.
// RULE_16: Comparator A has address, data, mask and control bytes, eight total.
// RULE_17: Comparators B and C have three address bytes and one control.
// RULE_18: Unimplemented window bytes read zero and ignore writes.
// RULE_19: Software must not program reserved select codes.
//
// Added by the designer: the AXI4-Lite slave port.
module dms_debug_match_sequencer
   import dms_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [dms_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [dms_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Monitored CPU bus, same clock.
   input wire logic [23:0] cpu_addr,
   input wire logic [15:0] cpu_data,
   input wire logic cpu_valid,
   // Debug state and interrupt.
   output logic [2:0] seq_state,
   output logic irq
);
   import dms_pkg::*;

   dms_state_t s;
   dms_state_t n;
   logic [2:0] m;
   logic session;
   logic aw_hs;
   logic w_hs;
   logic do_wr;
   logic ar_hs;
   logic [7:0] wr_idx;
   logic [31:0] wr_data;
   logic wr_byte;
   logic ctl_wr;
   logic arm_wr;
   dms_seq_t seq_nxt;

   // True where the word index has a register behind it.
   function automatic logic is_mapped(input logic [7:0] idx);
      is_mapped = (idx <= IDX_IRQ_MSK) || (idx[7:3] == IDX_WIN[7:3]);
   endfunction : is_mapped

   // Target of one channel's match in State3; SEQ_THREE means no move.
   function automatic dms_seq_t st3_target(input logic [3:0] code,
                                           input logic [1:0] ch);
      st3_target = SEQ_THREE;
      case (code)
         NSS_3: if (ch == 2'h1) st3_target = SEQ_FINAL;
               else if (ch == 2'h2) st3_target = SEQ_ONE;
         NSS_4: if (ch == 2'h1) st3_target = SEQ_TWO;
         NSS_5: if (ch == 2'h1) st3_target = SEQ_FINAL;
         NSS_6: if (ch == 2'h2) st3_target = SEQ_TWO;
               else if (ch == 2'h0) st3_target = SEQ_FINAL;
         NSS_7: if (ch == 2'h0) st3_target = SEQ_FINAL;
         NSS_A: if (ch == 2'h0) st3_target = SEQ_FINAL;
               else if (ch != 2'h3) st3_target = SEQ_ONE;
         NSS_D: if (ch == 2'h0) st3_target = SEQ_ONE;
               else if (ch != 2'h3) st3_target = SEQ_FINAL;
         NSS_E: if (ch == 2'h0) st3_target = SEQ_TWO;
               else if (ch == 2'h2) st3_target = SEQ_FINAL;
         default: st3_target = SEQ_THREE;
      endcase
   endfunction : st3_target

   // Read value of one register byte; used by the read path only once,
   // but kept apart so the window layout sits in one place.
   function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                           input dms_state_t st);
      logic [2:0] k;
      logic [1:0] b;
      k = idx[2:0];
      b = st.bank;
      reg_read = 8'h00;
      if (idx == IDX_CTRL)
      begin
         reg_read = {st.nss, st.bank, 1'b0,
                     (st.seq != SEQ_IDLE) && (st.seq != SEQ_FINAL)};
      end
      else if (idx == IDX_STAT)
      begin
         reg_read = {5'h00, st.seq};
      end
      else if (idx == IDX_IRQ_STS)
      begin
         reg_read = {6'h00, st.irq_sts};
      end
      else if (idx == IDX_IRQ_MSK)
      begin
         reg_read = {6'h00, st.irq_msk};
      end
      else if (idx == IDX_MATCH_FLAGS && b == BANK_FLAGS)
      begin
         reg_read = {5'h00, st.flags}; // RULE_09
      end
      else if (idx[7:3] == IDX_WIN[7:3] && b != BANK_FLAGS)
      begin
         // Bank B and C leave bytes 4..7 empty; they read as zero.
         case (k) // RULE_15
            3'h0: reg_read = st.cmp_ctl[b];
            3'h1: reg_read = st.cmp_addr[b][23:16];
            3'h2: reg_read = st.cmp_addr[b][15:8];
            3'h3: reg_read = st.cmp_addr[b][7:0];
            3'h4: reg_read = (b == 2'h0) ? st.a_data[15:8] : 8'h00; // RULE_18
            3'h5: reg_read = (b == 2'h0) ? st.a_data[7:0] : 8'h00;
            3'h6: reg_read = (b == 2'h0) ? st.a_mask[15:8] : 8'h00;
            3'h7: reg_read = (b == 2'h0) ? st.a_mask[7:0] : 8'h00;
            default: reg_read = 8'h00;
         endcase
      end
   endfunction : reg_read

   // Channel matches. Only A looks at data; a mask bit of one compares.
   generate
      for (genvar c = 0; c < 3; c++)
      begin : g_cmp
         if (c == 0)
         begin : g_a
            assign m[c] = cpu_valid && s.cmp_ctl[c][CMP_EN]
               && (cpu_addr == s.cmp_addr[c])
               && (!s.cmp_ctl[c][CMP_DATA_EN]
                   || (((cpu_data ^ s.a_data) & s.a_mask) == 16'h0000));
         end
         else
         begin : g_bc
            assign m[c] = cpu_valid && s.cmp_ctl[c][CMP_EN]
               && (cpu_addr == s.cmp_addr[c]);
         end
      end
   endgenerate

   // Handshakes are combinational; one write and one read in flight.
   assign awready = !s.aw_got && !s.bvalid;
   assign wready = !s.w_got && !s.bvalid;
   assign arready = !s.rvalid;
   assign aw_hs = awvalid && awready;
   assign w_hs = wvalid && wready;
   assign ar_hs = arvalid && arready;
   assign do_wr = !s.bvalid && (s.aw_got || awvalid) && (s.w_got || wvalid);
   assign wr_idx = s.aw_got ? s.aw_idx : awaddr[9:2];
   assign wr_data = s.w_got ? s.wdata : wdata;
   assign wr_byte = do_wr && (s.w_got ? s.wstrb[0] : wstrb[0]);
   assign ctl_wr = wr_byte && (wr_idx == IDX_CTRL);
   assign arm_wr = ctl_wr && wr_data[CTRL_ARM];
   assign session = (s.seq != SEQ_IDLE) && (s.seq != SEQ_FINAL);

   // Sequencer next state; the final target wins, then the lowest channel.
   always_comb
   begin
      dms_seq_t pick;
      logic fin;
      pick = SEQ_THREE;
      fin = 1'b0;
      seq_nxt = s.seq;
      case (s.seq)
         SEQ_ONE: if (m[0]) seq_nxt = SEQ_TWO;
         SEQ_TWO: if (m[1]) seq_nxt = SEQ_THREE;
         SEQ_THREE:
         begin
            for (int c = 2; c >= 0; c--)
            begin
               if (m[c] && st3_target(s.nss, c[1:0]) != SEQ_THREE)
               begin
                  pick = st3_target(s.nss, c[1:0]); // RULE_08
               end
               if (m[c] && st3_target(s.nss, c[1:0]) == SEQ_FINAL)
               begin
                  fin = 1'b1;
               end
            end
            // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 RULE_07
            seq_nxt = fin ? SEQ_FINAL : pick;
         end
         default: seq_nxt = s.seq;
      endcase
   end

   // Whole next-state copy: bus slave, registers, flags, interrupts.
   always_comb
   begin
      logic [1:0] b;
      logic [7:0] d;
      logic [1:0] ev;
      n = s;
      b = s.bank;
      d = wr_data[7:0];
      ev = 2'h0;
      if (bvalid && bready)
      begin
         n.bvalid = 1'b0;
      end
      if (do_wr)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
         if (aw_hs)
         begin
            n.aw_got = 1'b1;
            n.aw_idx = awaddr[9:2];
         end
         if (w_hs)
         begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
         end
      end
      if (rvalid && rready)
      begin
         n.rvalid = 1'b0;
      end
      if (ar_hs)
      begin
         n.rvalid = 1'b1;
         n.rdata = {24'h000000, reg_read(araddr[9:2], s)};
         n.rresp = is_mapped(araddr[9:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      // Sequencer; a control write arms or stops the session.
      n.seq = session ? seq_nxt : s.seq;
      if (ctl_wr)
      begin
         n.seq = wr_data[CTRL_ARM] ? SEQ_ONE : SEQ_IDLE;
         n.bank = wr_data[CTRL_BANK_LSB +: 2];
         n.nss = wr_data[CTRL_NSS_LSB +: 4];
      end
      // Only arming clears; a match in that cycle still lands if a session is running.
      // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
      n.flags = (arm_wr ? RST_FLAGS : s.flags) | (session ? m : 3'h0);
      // Window writes land in the bank that is selected.
      if (wr_byte && wr_idx[7:3] == IDX_WIN[7:3] && b != BANK_FLAGS)
      begin
         case (wr_idx[2:0]) // RULE_15 RULE_16 RULE_17
            3'h0: n.cmp_ctl[b] = d;
            3'h1: n.cmp_addr[b][23:16] = d;
            3'h2: n.cmp_addr[b][15:8] = d;
            3'h3: n.cmp_addr[b][7:0] = d;
            3'h4: if (b == 2'h0) n.a_data[15:8] = d; // RULE_18
            3'h5: if (b == 2'h0) n.a_data[7:0] = d;
            3'h6: if (b == 2'h0) n.a_mask[15:8] = d;
            3'h7: if (b == 2'h0) n.a_mask[7:0] = d;
            default: n.a_mask = s.a_mask;
         endcase
      end
      if (wr_byte && wr_idx == IDX_IRQ_MSK)
      begin
         n.irq_msk = d[1:0];
      end
      // Sticky events; a new event beats a write-one clear.
      ev[IRQ_FINAL] = session && (seq_nxt == SEQ_FINAL) && !ctl_wr;
      ev[IRQ_FLAG] = session && |(m & ~s.flags);
      n.irq_sts = s.irq_sts;
      if (wr_byte && wr_idx == IDX_IRQ_STS)
      begin
         n.irq_sts = s.irq_sts & ~d[1:0];
      end
      n.irq_sts = n.irq_sts | ev;
   end

   // Single state register.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.seq <= SEQ_IDLE;
         s.bank <= RST_BANK;
         s.nss <= RST_NSS;
         s.flags <= RST_FLAGS;
         s.irq_sts <= RST_IRQ;
         s.irq_msk <= RST_IRQ;
      end
      else
      begin
         s <= n;
      end
   end

   // Outputs straight from the state register.
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign seq_state = s.seq;
   assign irq = |(s.irq_sts & s.irq_msk);

   // Checks on the sequencer, the flags and the bus slave.
   property p_arm_clears;
      @(posedge aclk) disable iff (!aresetn)
      arm_wr && !(session && |m) |=> s.flags == 3'h0;
   endproperty
   a_arm_clears: assert property (p_arm_clears) // RULE_11
      else $error("Arming write did not clear match flags.");

   property p_flags_hold;
      @(posedge aclk) disable iff (!aresetn)
      !arm_wr |=> (s.flags & $past(s.flags)) == $past(s.flags);
   endproperty
   a_flags_hold: assert property (p_flags_hold) // RULE_12
      else $error("A match flag dropped without arming.");

   property p_flags_set;
      @(posedge aclk) disable iff (!aresetn)
      session && |m |=> (s.flags & $past(m)) == $past(m);
   endproperty
   a_flags_set: assert property (p_flags_set) // RULE_13
      else $error("A matching channel did not set its flag.");

   property p_code3;
      @(posedge aclk) disable iff (!aresetn)
      s.seq == SEQ_THREE && s.nss == NSS_3 && m == 3'h2 && !ctl_wr
      |=> s.seq == SEQ_FINAL && s.flags[1];
   endproperty
   a_code3: assert property (p_code3) // RULE_02
      else $error("Code 0011 channel 1 did not reach final.");

   property p_unlisted;
      @(posedge aclk) disable iff (!aresetn)
      s.seq == SEQ_THREE && s.nss == NSS_7 && !m[0] && !ctl_wr
      |=> s.seq == SEQ_THREE;
   endproperty
   a_unlisted: assert property (p_unlisted) // RULE_01
      else $error("Unlisted match moved the sequencer.");

   property p_prio;
      @(posedge aclk) disable iff (!aresetn)
      s.seq == SEQ_THREE && s.nss == NSS_E && m[0] && m[2] && !ctl_wr
      |=> s.seq == SEQ_FINAL;
   endproperty
   a_prio: assert property (p_prio) // RULE_08
      else $error("Final-state match lost its priority.");

   property p_flag_hidden;
      @(posedge aclk) disable iff (!aresetn)
      ar_hs && araddr[9:2] == IDX_MATCH_FLAGS && s.bank != BANK_FLAGS
      |=> rvalid && rdata == {24'h000000, ($past(s.bank) == 2'h0)
                              ? $past(s.a_mask[7:0]) : 8'h00};
   endproperty
   a_flag_hidden: assert property (p_flag_hidden) // RULE_09
      else $error("Match flags visible with wrong bank.");

   property p_wr_resp;
      @(posedge aclk) disable iff (!aresetn)
      do_wr |=> bvalid && !awready && !wready;
   endproperty
   a_wr_resp: assert property (p_wr_resp)
      else $error("Write response not raised after write.");

   c_final: cover property (@(posedge aclk) disable iff (!aresetn)
      s.seq == SEQ_THREE ##1 s.seq == SEQ_FINAL);
   c_flag_read: cover property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && araddr[9:2] == IDX_MATCH_FLAGS && s.bank == BANK_FLAGS);
   c_rearm: cover property (@(posedge aclk) disable iff (!aresetn)
      arm_wr && s.flags != 3'h0);

endmodule : dms_debug_match_sequencer

// >>> dms_cpu_model.sv
module dms_cpu_model
(
   // Clock of the monitored bus.
   input wire logic aclk,
   // Bus cycle lines toward the debug block.
   output logic [23:0] cpu_addr,
   output logic [15:0] cpu_data,
   output logic cpu_valid
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle lines start away from every programmed compare value.
   initial
   begin
      cpu_addr = 24'hFFFFFF;
      cpu_data = 16'hFFFF;
      cpu_valid = 1'b0;
   end

   // One bus cycle, then one idle cycle so callers may chain cycles.
   // Idle lines carry the inverse of the last value, so a block that
   // ignores the valid line sees a changed address rather than a stale one.
   task automatic cycle(input logic [23:0] a, input logic [15:0] d);
      cpu_addr <= a;
      cpu_data <= d;
      cpu_valid <= 1'b1;
      @(posedge aclk);
      cpu_valid <= 1'b0;
      cpu_addr <= ~a;
      cpu_data <= ~d;
      @(posedge aclk);
   endtask : cycle

endmodule : dms_cpu_model

// >>> test_debug_match_sequencer.sv
`define CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         bad_count++; \
         $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); \
      end \
   end

module test_debug_match_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   import dms_pkg::*;

   // Each entry: code, comparator C low address, probe address, state.
   // Only listed select codes are used; reserved ones stay unprogrammed.
   localparam logic [23:0] CASES [0:23] = '{
      24'h333224, 24'h333331, 24'h322224,
      24'h333113, 24'h433113, 24'h533113,
      24'h433222, 24'h533224,
      24'h633332, 24'h633114, 24'h733114, 24'h733223,
      24'hA33221, 24'hA33331, 24'hA33114,
      24'hD33224, 24'hD33111,
      24'hE33112, 24'hE33334,
      24'h611114, 24'hA11114, 24'hD11114, 24'hE22224,
      24'hE11114
   };

   int bad_count = 0;
   int tests_run = 0;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic awvalid = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'b0;
   logic bready = 1'b1;
   logic [ADDR_W-1:0] araddr = '0;
   logic arvalid = 1'b0;
   logic rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, last_b, last_r;
   logic [31:0] rdata, rv;
   logic [23:0] cpu_addr;
   logic [15:0] cpu_data;
   logic cpu_valid;
   logic [2:0] seq_state;
   logic [23:0] e;

   // Free-running bus clock.
   always #20 aclk = ~aclk;

   dms_debug_match_sequencer u_dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_valid(cpu_valid),
      .seq_state(seq_state), .irq(irq));

   dms_cpu_model u_cpu (.aclk(aclk), .cpu_addr(cpu_addr),
      .cpu_data(cpu_data), .cpu_valid(cpu_valid));

   // Write one register; the address valid and the data valid are each released when taken.
   // Response ready stays high, so no edge is lost waiting for it.
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic a;
      logic w;
      a = 1'b1;
      w = 1'b1;
      awaddr <= {idx, 2'h0};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (a || w)
      begin
         @(posedge aclk);
         if (a && awready === 1'b1)
         begin
            a = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1)
         begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      last_b = bresp;
   endtask : wr

   // Read one register and keep its response code.
   task automatic rd(input logic [7:0] idx, output logic [31:0] d);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      last_r = rresp;
   endtask : rd

   // Print the counts and the verdict, then stop.
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   // A hung handshake must not stall the run forever.
   initial
   begin
      repeat (6000) @(posedge aclk);
      bad_count++;
      summarize();
   end

   // Main sequence.
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 4; i++)
      begin
         rd(8'(i), rv);
         `CHK(rv, 32'h00000000)
      end
      // Comparators A, B, C watch addresses 11, 22, 33.
      for (int b = 0; b < 3; b++)
      begin
         wr(IDX_CTRL, {4'h0, 2'(b), 2'h0});
         wr(IDX_WIN, 8'h01);
         wr(IDX_WIN + 8'h03, 8'(8'h11 * (b + 1)));
      end
      for (int k = 0; k < 24; k++)
      begin
         e = CASES[k];
         wr(IDX_CTRL, {e[23:20], 4'h8});
         wr(IDX_WIN + 8'h03, e[19:12]);
         wr(IDX_CTRL, {e[23:20], 4'hD});
         u_cpu.cycle(24'h000011, 16'h0000);
         u_cpu.cycle(24'h000022, 16'h0000);
         `CHK(seq_state, SEQ_THREE)
         u_cpu.cycle({16'h0000, e[11:4]}, 16'h0000);
         `CHK(seq_state, e[2:0])
      end
      // Flags: cleared by arming, kept through writes and session end.
      wr(IDX_CTRL, 8'h38);
      wr(IDX_WIN + 8'h03, 8'h33);
      wr(IDX_CTRL, 8'h3D);
      rd(IDX_MATCH_FLAGS, rv);
      `CHK(rv, 32'h00000000)
      u_cpu.cycle(24'h000011, 16'h0000);
      u_cpu.cycle(24'h000022, 16'h0000);
      u_cpu.cycle(24'h000022, 16'h0000);
      rd(IDX_MATCH_FLAGS, rv);
      `CHK(rv, 32'h00000003)
      wr(IDX_MATCH_FLAGS, 8'h00);
      `CHK(last_b, RESP_OKAY)
      wr(IDX_IRQ_MSK, 8'h00);
      rd(IDX_MATCH_FLAGS, rv);
      `CHK(rv, 32'h00000003)
      wr(IDX_CTRL, 8'h3C);
      rd(IDX_MATCH_FLAGS, rv);
      `CHK(rv, 32'h00000003)
      wr(IDX_CTRL, 8'h30);
      rd(IDX_MATCH_FLAGS, rv);
      `CHK(rv, 32'h00000000)
      // Interrupt: both events pending, masked, then cleared one by one.
      `CHK(irq, 1'b0)
      wr(IDX_IRQ_MSK, 8'h01);
      `CHK(irq, 1'b1)
      wr(IDX_IRQ_STS, 8'h01);
      `CHK(irq, 1'b0)
      rd(IDX_IRQ_STS, rv);
      `CHK(rv, 32'h00000002)
      wr(IDX_IRQ_MSK, 8'h02);
      `CHK(irq, 1'b1)
      wr(IDX_IRQ_STS, 8'h02);
      `CHK(irq, 1'b0)
      wr(IDX_CTRL, 8'h3D);
      rd(IDX_MATCH_FLAGS, rv);
      `CHK(rv, 32'h00000000)
      // Window: A keeps data and mask bytes, B and C read zero there.
      for (int b = 0; b < 3; b++)
      begin
         wr(IDX_CTRL, {4'h3, 2'(b), 2'h0});
         rd(IDX_WIN + 8'h03, rv);
         `CHK(rv, 32'(8'h11 * (b + 1)))
         for (int i = 4; i < 8; i++)
         begin
            wr(IDX_WIN + 8'(i), 8'(8'hA0 + i));
            rd(IDX_WIN + 8'(i), rv);
            `CHK(rv, (b == 0) ? 32'(8'hA0 + i) : 32'h0)
         end
      end
      // Data compare on A: masked-off bits are ignored, others must agree.
      wr(IDX_CTRL, 8'h70);
      wr(IDX_WIN, 8'h03);
      wr(IDX_CTRL, 8'h7D);
      u_cpu.cycle(24'h000011, 16'h0000);
      `CHK(seq_state, SEQ_ONE)
      u_cpu.cycle(24'h000011, 16'hFDFD);
      `CHK(seq_state, SEQ_TWO)
      // Unmapped index refuses both directions.
      wr(8'h10, 8'hFF);
      `CHK(last_b, RESP_SLVERR)
      rd(8'h10, rv);
      `CHK({last_r, rv}, {RESP_SLVERR, 32'h00000000})
      summarize();
   end

endmodule : test_debug_match_sequencer
